// ### hw/pse_link_rx.sv
// Purpose: captures the data line on each rising edge of the serial clock
// Assumes: serial clock stops between frames
// Notes:   a toggle marks each new bit for the system clock side
module pse_link_rx (
	input  wire logic scl_clk,
	input  wire logic rst_n,
	input  wire logic sda_in,
	output logic      bit_reg,
	output logic      tog_reg
);
	// data is sampled on the rising serial clock edge, where it must be steady
	always_ff @(posedge scl_clk or negedge rst_n) begin
		if (!rst_n) begin
			bit_reg <= 1'b1;
			tog_reg <= 1'b0;
		end else begin
			bit_reg <= sda_in;
			tog_reg <= ~tog_reg;
		end
	end
endmodule : pse_link_rx

// ### hw/pse_pkg.sv
// Purpose: shared constants and types for the supply status/enable bank
// Assumes: byte-wide registers behind a two-wire serial target port
// Notes:   supply fields occupy bits 5 down to 1 of the status, mask and enable registers
package pse_pkg;
	localparam logic [6:0] PSE_DEV_ADDR   = 7'h48;
	localparam logic [7:0] PSE_REG_REV    = 8'h00;
	localparam logic [7:0] PSE_REG_STAT   = 8'h01;
	localparam logic [7:0] PSE_REG_MASK   = 8'h02;
	localparam logic [7:0] PSE_REG_ENA    = 8'h03;
	localparam logic [7:0] PSE_MASK_RST   = 8'hC0;
	localparam logic [7:0] PSE_ENA_RST    = 8'hFF;
	localparam logic [7:0] PSE_UNMAPPED   = 8'hFF;
	localparam logic [2:0] PSE_LAST_BIT   = 3'h7;
	localparam int         PSE_ST_PF      = 7;
	localparam int         PSE_ST_LB      = 6;
	localparam int         PSE_SUP_HI     = 5;
	localparam int         PSE_ST_B3      = 3;
	localparam int         PSE_SUP_LO     = 1;
	localparam int         PSE_SYNC_W     = 14;

	typedef logic [PSE_SUP_HI:PSE_SUP_LO] pse_sup_t;
	typedef logic [PSE_ST_PF:PSE_SUP_LO]  pse_flags_t;

	typedef enum logic [2:0] {
		PSE_IDLE,
		PSE_ADDR,
		PSE_REG,
		PSE_WDATA,
		PSE_ACK,
		PSE_RDATA,
		PSE_RDATA_ACK
	} pse_state_t;
endpackage : pse_pkg

// ### hw/pse_regs_top.sv
// Purpose: supply status, mask and enable registers behind a serial target
// Assumes: clock 20 MHz; rst_n is the supply lockout, async, active low
// Notes:   serial clock clocks the bit capture; all else on clock
//
// Overview of operation
// - data changes only while serial clock low; steady while high
// - data edge during clock high means start or stop; frames bracket
// - device pulls data low through the ack clock of each byte
// - on a read not acknowledged, device releases data high
// - read-only revision code register at address zero
// - read-only status register at address one, bit 0 unused
// - bits 7 and 6 show power-fail and low-battery sense below threshold
// - bits 5 to 1 show each supply below its regulation target
// - supply status bit reads 0 while that supply is disabled
// - third buck status bit reads 0 during a voltage step
// - mask bit 1 hides status bit from interrupt; reset value C0
// - enable register bits 5 to 1 control the five supplies
// - supply runs only when register bit and its pin are both high
// - lockout resets the enable register to all ones
// - low enable pin keeps forcing its register bit to 1
// - respond only to bus address 1001000
// - reads of unimplemented addresses return FF
// - interrupt low while any unmasked fault exists, else released; code also pulls it low while no supply is enabled
// - reading status releases the interrupt, status bits stay
module pse_regs_top
	import pse_pkg::*;
#(
	parameter logic [7:0] REV_CODE = 8'h5A  // arbitrary value
) (
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic scl,
	input  wire logic sda_i,
	output logic      sda_o,
	output logic      sda_oe,
	output logic      int_o,
	output logic      int_oe,
	input  wire logic power_fail_sense,
	input  wire logic low_battery_sense,
	input  wire pse_sup_t supply_below,
	input  wire logic dynamic_voltage_step,
	input  wire logic core_buck_enable_pin,
	input  wire logic second_buck_enable_pin,
	input  wire logic third_buck_enable_pin,
	input  wire logic linear_regs_enable_pin,
	output pse_sup_t  supply_on
);
	logic                  link_bit;
	logic                  link_tog;
	logic                  tog_s;
	logic                  tog_d_reg;
	logic                  bit_evt;
	logic [PSE_SYNC_W-1:0] pin_s;
	logic                  scl_s;
	logic                  sda_s;
	logic                  pf_s;
	logic                  lb_s;
	pse_sup_t              below_s;
	logic                  dvs_s;
	logic                  core_s;
	logic                  b2_s;
	logic                  b3_s;
	logic                  lin_s;
	logic                  scl_d_reg;
	logic                  sda_d_reg;
	logic                  start_det;
	logic                  stop_det;
	logic                  scl_fall;
	pse_sup_t              pin_en;
	pse_sup_t              en_reg;
	pse_sup_t              en_eff;
	pse_sup_t              dvs_gate;
	pse_flags_t            mask_reg;
	logic [7:0]            status_reg;
	logic [7:0]            status_next;
	pse_state_t            state_reg;
	pse_state_t            after_reg;
	logic [7:0]            shift_reg;
	logic [2:0]            cnt_reg;
	logic [7:0]            ptr_reg;
	logic                  full_reg;
	logic                  master_ack_reg;
	logic                  wr_pulse_reg;
	logic [7:0]            wr_addr_reg;
	logic [7:0]            wr_data_reg;
	logic                  stat_rd_reg;
	logic [7:0]            rd_word;
	logic [7:0]            pend;
	logic [7:0]            snap_reg;
	logic                  released_reg;

	pse_link_rx u_link (
		.scl_clk (scl),
		.rst_n   (rst_n),
		.sda_in  (sda_i),
		.bit_reg (link_bit),
		.tog_reg (link_tog)
	);

	pse_sync2 #(.WIDTH(1)) u_tog_sync (
		.clock (clock),
		.rst_n (rst_n),
		.d     (link_tog),
		.q     (tog_s)
	);

	pse_sync2 #(.WIDTH(PSE_SYNC_W)) u_pin_sync (
		.clock (clock),
		.rst_n (rst_n),
		.d     ({scl, sda_i, power_fail_sense, low_battery_sense,
		         supply_below, dynamic_voltage_step, core_buck_enable_pin,
		         second_buck_enable_pin, third_buck_enable_pin,
		         linear_regs_enable_pin}),
		.q     (pin_s)
	);

	assign {scl_s, sda_s, pf_s, lb_s, below_s, dvs_s,
	        core_s, b2_s, b3_s, lin_s} = pin_s;

	// one linear pin governs both linear supplies
	assign pin_en = {core_s, b2_s, b3_s, lin_s, lin_s};
	assign en_eff = en_reg & pin_en;

	// edge detection; reset level matches the synchroniser, so no false edge
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			scl_d_reg <= 1'b0;
			sda_d_reg <= 1'b0;
			tog_d_reg <= 1'b0;
		end else begin
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
			tog_d_reg <= tog_s;
		end
	end

	assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	assign stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
	assign scl_fall  = scl_d_reg & ~scl_s;
	assign bit_evt   = tog_s ^ tog_d_reg;

	// read mux
	always_comb begin
		unique case (ptr_reg)
			PSE_REG_REV:  rd_word = REV_CODE;
			PSE_REG_STAT: rd_word = status_reg;
			PSE_REG_MASK: rd_word = {mask_reg, 1'b0};
			PSE_REG_ENA:  rd_word = {PSE_ENA_RST[7:PSE_SUP_HI+1], en_reg,
			                         PSE_ENA_RST[0]};
			default:      rd_word = PSE_UNMAPPED;
		endcase
	end

	// status composition
	always_comb begin
		dvs_gate            = '1;
		dvs_gate[PSE_ST_B3] = ~dvs_s;
		status_next         = '0;
		status_next[PSE_ST_PF] = pf_s;
		status_next[PSE_ST_LB] = lb_s;
		status_next[PSE_SUP_HI:PSE_SUP_LO] =
			below_s & en_eff & dvs_gate;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			status_reg <= '0;
		end else begin
			status_reg <= status_next;
		end
	end

	// protocol engine
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_reg      <= PSE_IDLE;
			after_reg      <= PSE_IDLE;
			shift_reg      <= '0;
			cnt_reg        <= '0;
			ptr_reg        <= '0;
			full_reg       <= 1'b0;
			master_ack_reg <= 1'b0;
			sda_oe         <= 1'b0;
			wr_pulse_reg   <= 1'b0;
			wr_addr_reg    <= '0;
			wr_data_reg    <= '0;
			stat_rd_reg    <= 1'b0;
		end else begin
			wr_pulse_reg <= 1'b0;
			stat_rd_reg  <= 1'b0;
			if (start_det) begin
				state_reg <= PSE_ADDR;
				cnt_reg   <= '0;
				full_reg  <= 1'b0;
				sda_oe    <= 1'b0;
			end else if (stop_det) begin
				state_reg <= PSE_IDLE;
				sda_oe    <= 1'b0;
			end else begin
				unique case (state_reg)
					PSE_IDLE: begin
						sda_oe <= 1'b0;
					end
					PSE_ADDR, PSE_REG, PSE_WDATA: begin
						if (bit_evt && !full_reg) begin
							shift_reg <= {shift_reg[6:0], link_bit};
							cnt_reg   <= 3'(cnt_reg + 3'h1);
							full_reg  <= (cnt_reg == PSE_LAST_BIT);
						end else if (scl_fall && full_reg) begin
							full_reg <= 1'b0;
							if (state_reg == PSE_ADDR) begin
								if (shift_reg[7:1] == PSE_DEV_ADDR) begin
									sda_oe    <= 1'b1;
									state_reg <= PSE_ACK;
									after_reg <= shift_reg[0] ? PSE_RDATA : PSE_REG;
								end else begin
									state_reg <= PSE_IDLE;
								end
							end else begin
								sda_oe    <= 1'b1;
								state_reg <= PSE_ACK;
								after_reg <= PSE_WDATA;
								if (state_reg == PSE_REG) begin
									ptr_reg <= shift_reg;
								end else begin
									wr_pulse_reg <= 1'b1;
									wr_addr_reg  <= ptr_reg;
									wr_data_reg  <= shift_reg;
									ptr_reg      <= 8'(ptr_reg + 8'h01);
								end
							end
						end
					end
					PSE_ACK: begin
						if (scl_fall) begin
							state_reg <= after_reg;
							cnt_reg   <= '0;
							if (after_reg == PSE_RDATA) begin
								shift_reg   <= rd_word;
								sda_oe      <= ~rd_word[7];
								stat_rd_reg <= (ptr_reg == PSE_REG_STAT);
								ptr_reg     <= 8'(ptr_reg + 8'h01);
							end else begin
								sda_oe <= 1'b0;
							end
						end
					end
					PSE_RDATA: begin
						if (scl_fall) begin
							if (cnt_reg == PSE_LAST_BIT) begin
								sda_oe    <= 1'b0;
								state_reg <= PSE_RDATA_ACK;
							end else begin
								shift_reg <= {shift_reg[6:0], 1'b0};
								sda_oe    <= ~shift_reg[6];
								cnt_reg   <= 3'(cnt_reg + 3'h1);
							end
						end
					end
					PSE_RDATA_ACK: begin
						if (bit_evt) begin
							master_ack_reg <= ~link_bit;
						end else if (scl_fall) begin
							if (master_ack_reg) begin
								state_reg   <= PSE_RDATA;
								cnt_reg     <= '0;
								shift_reg   <= rd_word;
								sda_oe      <= ~rd_word[7];
								stat_rd_reg <= (ptr_reg == PSE_REG_STAT);
								ptr_reg     <= 8'(ptr_reg + 8'h01);
							end else begin
								sda_oe    <= 1'b0;
								state_reg <= PSE_IDLE;
							end
						end
					end
				endcase
			end
		end
	end

	// mask register; read-only addresses simply fall through
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mask_reg <= PSE_MASK_RST[PSE_ST_PF:PSE_SUP_LO];
		end else if (wr_pulse_reg && wr_addr_reg == PSE_REG_MASK) begin
			mask_reg <= wr_data_reg[PSE_ST_PF:PSE_SUP_LO];
		end
	end

	// enable register; a low pin keeps its bit at 1
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			en_reg <= PSE_ENA_RST[PSE_SUP_HI:PSE_SUP_LO];
		end else if (wr_pulse_reg && wr_addr_reg == PSE_REG_ENA) begin
			en_reg <= wr_data_reg[PSE_SUP_HI:PSE_SUP_LO] | ~pin_en;
		end else begin
			en_reg <= en_reg | ~pin_en;
		end
	end

	// interrupt: unmasked faults, or no supply enabled at all
	assign pend = {status_reg[PSE_ST_PF:PSE_SUP_LO] & ~mask_reg,
	               ~|en_eff};

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			released_reg <= 1'b0;
			snap_reg     <= '0;
		end else if (stat_rd_reg && int_oe) begin
			released_reg <= 1'b1;
			snap_reg     <= pend;
		end else if (pend == '0 || (pend & ~snap_reg) != '0) begin
			released_reg <= 1'b0;
			snap_reg     <= '0;
		end
	end

	// outputs from flops
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			int_oe    <= 1'b0;
			int_o     <= 1'b0;
			sda_o     <= 1'b0;
			supply_on <= '0;
		end else begin
			int_oe    <= (|pend) & ~released_reg;
			int_o     <= 1'b0;
			sda_o     <= 1'b0;
			supply_on <= en_eff;
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_sda_change_low: assert property ($changed(sda_oe) |-> !scl_s)
		else $error("data line moved while clock high");
	a_stop_idles: assert property (
		stop_det && !start_det |=> state_reg == PSE_IDLE && !sda_oe)
		else $error("stop did not end the frame");
	a_ack_drive: assert property (state_reg == PSE_ACK |-> sda_oe)
		else $error("ack not driven low");
	a_nack_release: assert property (
		state_reg == PSE_RDATA_ACK && scl_fall && !bit_evt && !start_det
		&& !stop_det && !master_ack_reg
		|=> !sda_oe && state_reg == PSE_IDLE)
		else $error("data line held after nack");
	a_addr_ignore: assert property (
		state_reg == PSE_ADDR && scl_fall && full_reg && !start_det
		&& !stop_det && shift_reg[7:1] != PSE_DEV_ADDR
		|=> state_reg == PSE_IDLE && !sda_oe)
		else $error("answered foreign address");
	a_unmapped_ff: assert property (
		ptr_reg > PSE_REG_ENA |-> rd_word == PSE_UNMAPPED)
		else $error("unmapped read not FF");
	a_status_off: assert property (
		1'b1 |=> ((status_reg[PSE_SUP_HI:PSE_SUP_LO] & ~$past(en_eff)) == '0)
		&& !status_reg[0])
		else $error("disabled supply shows fault");
	a_dvs_blank: assert property (dvs_s |=> !status_reg[PSE_ST_B3])
		else $error("third buck fault during voltage step");
	a_pin_forces: assert property (
		1'b1 |=> (en_reg | $past(pin_en)) == '1)
		else $error("enable bit not forced by low pin");
	a_supply_and: assert property (
		1'b1 |=> ##1 supply_on == $past(en_reg & pin_en))
		else $error("supply on differs from and of bit and pin");
	a_int_fault: assert property (|pend && !released_reg |=> int_oe)
		else $error("interrupt not asserted on fault");
	a_int_clear: assert property (pend == '0 |=> !int_oe)
		else $error("interrupt held with no fault");
	a_stat_release: assert property (
		stat_rd_reg && int_oe
		|=> released_reg ##1 (!int_oe || $past(pend & ~snap_reg) != '0))
		else $error("status read did not release interrupt");
endmodule : pse_regs_top

// ### hw/pse_sync2.sv
// Purpose: two-stage synchroniser for levels entering the system clock
// Assumes: each bit is an independent level
// Notes:   first stage feeds only the second stage
module pse_sync2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             clock,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= '0;
			q        <= '0;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule : pse_sync2

// ### testbench/pse_host_model.sv
// Purpose: serial bus host driving the register bank target port
// Assumes: open-drain data line with pull-up resolved by the bench
// Notes:   timing unit of 48 ns; serial clock stands high between frames
module pse_host_model
	import pse_pkg::*;
(
	output logic      scl,
	output logic      sda_low,
	input  wire logic sda
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int Q = 48;

	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	task automatic put_bit(input logic b);
		#(7*Q) sda_low = ~b;
		#(21*Q) scl = 1'b1;
		#(14*Q) scl = 1'b0;
	endtask : put_bit

	task automatic get_bit(output logic b);
		#(7*Q) sda_low = 1'b0;
		#(21*Q) scl = 1'b1;
		#(7*Q) b = sda;
		#(7*Q) scl = 1'b0;
	endtask : get_bit

	task automatic start();
		if (scl == 1'b0) begin
			#(7*Q) sda_low = 1'b0;
			#(21*Q) scl = 1'b1;
		end
		#(14*Q) sda_low = 1'b1;
		#(14*Q) scl = 1'b0;
	endtask : start

	task automatic stop();
		#(7*Q) sda_low = 1'b1;
		#(21*Q) scl = 1'b1;
		#(14*Q) sda_low = 1'b0;
		#(28*Q);
	endtask : stop

	task automatic send(input logic [7:0] d, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) put_bit(d[i]);
		get_bit(a);
		ack = ~a;
	endtask : send

	// last byte: release the line instead of acking, and see it stay high
	task automatic recv(output logic [7:0] d, output logic rel);
		for (int i = 7; i >= 0; i--) get_bit(d[i]);
		get_bit(rel);
	endtask : recv

	task automatic write_reg(input logic [7:0] a, input logic [7:0] p,
		input logic [7:0] d, output logic [2:0] k);
		k = 3'h0;
		start();
		send(a, k[2]);
		if (k[2]) begin
			send(p, k[1]);
			send(d, k[0]);
		end
		stop();
	endtask : write_reg

	task automatic read_reg(input logic [7:0] a, input logic [7:0] p,
		output logic [7:0] d, output logic [2:0] k, output logic rel);
		start();
		send(a, k[2]);
		send(p, k[1]);
		start();
		send(a | 8'h01, k[0]);
		recv(d, rel);
		stop();
	endtask : read_reg

	// two data bytes in one write; pointer steps between them
	task automatic write_two(input logic [7:0] a, input logic [7:0] p,
		input logic [15:0] d, output logic [3:0] k);
		start();
		send(a, k[3]);
		send(p, k[2]);
		send(d[15:8], k[1]);
		send(d[7:0], k[0]);
		stop();
	endtask : write_two

	// two bytes in one read: ack the first, release after the second
	task automatic read_two(input logic [7:0] a, input logic [7:0] p,
		output logic [15:0] d, output logic [2:0] k, output logic rel);
		start();
		send(a, k[2]);
		send(p, k[1]);
		start();
		send(a | 8'h01, k[0]);
		for (int i = 15; i >= 8; i--) get_bit(d[i]);
		put_bit(1'b0);
		recv(d[7:0], rel);
		stop();
	endtask : read_two
endmodule : pse_host_model

// ### testbench/testbench.sv
// Purpose: self-checking bench for the supply status and enable bank
// Assumes: host model owns the serial lines; pins driven here
// Notes:   each scenario reads back through the serial port
module testbench
	import pse_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] REV = 8'h3C; // arbitrary value
	localparam logic [7:0] DA  = {PSE_DEV_ADDR, 1'b0};
	localparam int         LIMIT = 80000;

	logic     clock, rst_n, scl, host_low, sda, sda_o, sda_oe;
	logic     int_o, int_oe, pf, lb, dvs, pin_c, pin_s, pin_t, pin_l;
	pse_sup_t below, supply_on;
	int       mismatches, checks_done, cycles;

	assign sda = host_low ? 1'b0 : (sda_oe ? sda_o : 1'b1);

	pse_host_model host (.scl(scl), .sda_low(host_low), .sda(sda));

	pse_regs_top #(.REV_CODE(REV)) DUT (
		.clock(clock), .rst_n(rst_n), .scl(scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe(sda_oe), .int_o(int_o), .int_oe(int_oe),
		.power_fail_sense(pf), .low_battery_sense(lb),
		.supply_below(below), .dynamic_voltage_step(dvs),
		.core_buck_enable_pin(pin_c), .second_buck_enable_pin(pin_s),
		.third_buck_enable_pin(pin_t), .linear_regs_enable_pin(pin_l),
		.supply_on(supply_on)
	);

	always #25 clock = ~clock;

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : summarize

	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			mismatches++;
			summarize();
		end
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic rd(input logic [7:0] p, output logic [7:0] d);
		logic [2:0] k;
		logic       rel;
		host.read_reg(DA, p, d, k, rel);
		check({5'h0, k}, 8'h07);
		check({7'h0, rel}, 8'h01);
	endtask : rd

	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		logic [2:0] k;
		host.write_reg(DA, p, d, k);
		check({5'h0, k}, 8'h07);
	endtask : wr

	task automatic settle();
		repeat (10) @(posedge clock);
	endtask : settle

	task automatic t_defaults();
		logic [7:0] d;
		rd(PSE_REG_REV, d);
		check(d, REV);
		rd(PSE_REG_MASK, d);
		check(d, PSE_MASK_RST);
		rd(PSE_REG_ENA, d);
		check(d, PSE_ENA_RST);
		rd(8'h04, d);
		check(d, PSE_UNMAPPED);
		rd(8'h7E, d);
		check(d, 8'hFF);
		$display("test defaults done");
	endtask : t_defaults

	task automatic t_status();
		logic [7:0] d;
		@(posedge clock);
		pf <= 1'b1;
		below <= 5'b10110;
		settle();
		rd(PSE_REG_STAT, d);
		check(d, 8'hAC);
		@(posedge clock);
		pf <= 1'b0;
		lb <= 1'b1;
		below <= 5'b11111;
		pin_c <= 1'b0;
		dvs <= 1'b1;
		settle();
		rd(PSE_REG_STAT, d);
		check(d, 8'h56);
		@(posedge clock);
		lb <= 1'b0;
		below <= 5'b00000;
		pin_c <= 1'b1;
		dvs <= 1'b0;
		settle();
		$display("test status done");
	endtask : t_status

	task automatic t_enable();
		logic [7:0] d;
		wr(PSE_REG_ENA, 8'h00);
		rd(PSE_REG_ENA, d);
		check(d, 8'hC1);
		check({3'h0, supply_on}, 8'h00);
		wr(PSE_REG_ENA, 8'h2A);
		@(posedge clock);
		pin_s <= 1'b0;
		settle();
		check({3'h0, supply_on}, 8'h15);
		rd(PSE_REG_ENA, d);
		check(d, 8'hFB);
		@(posedge clock);
		pin_s <= 1'b1;
		pin_l <= 1'b0;
		settle();
		check({3'h0, supply_on}, 8'h1C);
		wr(PSE_REG_ENA, 8'h00);
		rd(PSE_REG_ENA, d);
		check(d, 8'hC7);
		@(posedge clock);
		pin_l <= 1'b1;
		settle();
		check({3'h0, supply_on}, 8'h03);
		wr(PSE_REG_ENA, 8'hFF);
		$display("test enable done");
	endtask : t_enable

	task automatic t_readonly();
		logic [7:0] d;
		wr(PSE_REG_REV, 8'hAA);
		wr(PSE_REG_STAT, 8'hAA);
		rd(PSE_REG_REV, d);
		check(d, REV);
		rd(PSE_REG_STAT, d);
		check(d, 8'h00);
		$display("test read-only done");
	endtask : t_readonly

	task automatic t_address();
		logic [7:0] d;
		logic [2:0] k;
		host.write_reg(8'h92, PSE_REG_ENA, 8'h00, k);
		check({5'h0, k}, 8'h00);
		rd(PSE_REG_ENA, d);
		check(d, 8'hFF);
		$display("test address done");
	endtask : t_address

	task automatic t_irq();
		logic [7:0] d;
		settle();
		check({7'h0, int_oe}, 8'h00);
		@(posedge clock);
		below <= 5'b00010;
		settle();
		check({7'h0, int_oe}, 8'h01);
		check({7'h0, int_o}, 8'h00);
		rd(PSE_REG_STAT, d);
		settle();
		check(d, 8'h04);
		check({7'h0, int_oe}, 8'h00);
		@(posedge clock);
		below <= 5'b00000;
		settle();
		wr(PSE_REG_MASK, 8'h04);
		rd(PSE_REG_MASK, d);
		check(d, 8'h04);
		@(posedge clock);
		below <= 5'b00010;
		settle();
		check({7'h0, int_oe}, 8'h00);
		@(posedge clock);
		below <= 5'b00000;
		pf <= 1'b1;
		settle();
		check({7'h0, int_oe}, 8'h01);
		@(posedge clock);
		pf <= 1'b0;
		settle();
		wr(PSE_REG_MASK, PSE_MASK_RST);
		$display("test interrupt done");
	endtask : t_irq

	task automatic t_lockout();
		logic [15:0] d;
		logic [2:0]  k;
		logic [3:0]  w;
		logic        rel;
		host.write_two(DA, PSE_REG_MASK, 16'h3E00, w);
		check({4'h0, w}, 8'h0F);
		host.read_two(DA, PSE_REG_MASK, d, k, rel);
		check({5'h0, k}, 8'h07);
		check({7'h0, rel}, 8'h01);
		check(d[15:8], 8'h3E);
		check(d[7:0], 8'hC1);
		@(posedge clock);
		rst_n <= 1'b0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		settle();
		check({3'h0, supply_on}, 8'h1F);
		host.read_two(DA, PSE_REG_MASK, d, k, rel);
		check(d[15:8], PSE_MASK_RST);
		check(d[7:0], PSE_ENA_RST);
		$display("test lockout done");
	endtask : t_lockout

	initial begin
		clock = 1'b0;
		rst_n = 1'b0;
		{pf, lb, dvs} = 3'h0;
		{pin_c, pin_s, pin_t, pin_l} = 4'hF;
		below = 5'h00;
		mismatches = 0;
		checks_done = 0;
		cycles = 0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		repeat (6) @(posedge clock);
		t_defaults();
		t_status();
		t_enable();
		t_readonly();
		t_address();
		t_irq();
		t_lockout();
		summarize();
	end
endmodule : testbench
